// ---- verilog/mdma_top.sv ----
/*
 multichannel descriptor dma: register port, trigger selection, arbitration,
 address cache, descriptor fetch and one memory master port.
 assumes all inputs synchronous to clk_sys and a memory that answers each
 request with a one-cycle mem_ack, read data valid beside it.
*/
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "mdma_regs.svh"
module mdma_top
   import mdma_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire mdma_reg_t             reg_req,
   output      logic [31:0]           reg_rdata,
   input  wire logic [`MDMA_NREQ-1:0] periph_req,
   input  wire logic [`MDMA_NEXT-1:0] trig_ext,
   input  wire logic                  mem_ack,
   input  wire logic [31:0]           mem_rdata,
   output      mdma_mem_t             mem,
   output      logic [`MDMA_NREQ-1:0] req_ack,
   output      logic [`MDMA_NCH-1:0]  trig_out,
   output      logic                  irq
);

   mdma_core_t           st;
   mdma_core_t           next_st;
   logic [`MDMA_NROUTE-1:0] outs;
   logic [`MDMA_NCH-1:0] tv;
   logic [`MDMA_NCH-1:0] reqv;
   logic [`MDMA_NCH-1:0] ackv;
   logic                 found;
   logic [4:0]           best;
   logic [2:0]           bprio;
   logic [2:0]           hit;
   logic [4:0]           wch;
   mdma_xfer_t           cur_x;
   mdma_cache_t          cur_c;
   mdma_cfg_t            cur_g;
   logic [31:0]          desc_cur;
   logic [18:0]          rdata_cfg;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic trig_pick(input logic [4:0] sel, input logic [15:0] ext,
                                      input logic [3:0] o);
      logic r;
      r = 1'b0;
      if (sel < 5'(`MDMA_NEXT))
         r = ext[sel[3:0]];
      else if (sel < 5'(`MDMA_NTRIG))
         r = o[sel[1:0]];
      return r;
   endfunction

   function automatic logic [31:0] work_addr(input logic [31:0] end_a, input logic [9:0] rem,
                                             input logic [1:0] step, input logic [1:0] width);
      logic [31:0] off;
      off = {22'h00_0000, rem};
      if (step == 2'h0)
         return end_a;
      off = off << (3'(width) + 3'(step) - 3'h1);
      return end_a - off;
   endfunction

   function automatic logic [2:0] cache_find(input mdma_cache_t [`MDMA_NCACHE-1:0] c,
                                             input logic [4:0] ch);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < `MDMA_NCACHE; i++)
      begin
         if (c[i].valid && c[i].ch == ch)
            r = {1'b1, 2'(i)};
      end
      return r;
   endfunction

   function automatic logic [4:0] ch_index(input logic [9:0] a);
      logic [9:0] d;
      d = (a - `MDMA_CH_BASE) >> 4;
      return d[4:0];
   endfunction

   function automatic logic ch_space(input logic [9:0] a);
      return (a >= `MDMA_CH_BASE) && (a <= `MDMA_CH_LAST);
   endfunction

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      next_st = st;
      next_st.trig_out = '0;
      next_st.req_ack = '0;
      next_st.rdata = '0;
      found = 1'b0;
      best = 5'h00;
      bprio = `MDMA_RST_PRIO;
      hit = cache_find(st.cache, st.ch);
      wch = ch_index(reg_req.addr);
      cur_x = st.xfer[st.ch];
      cur_c = st.cache[st.slot];
      cur_g = st.cfg[st.ch];
      desc_cur = st.desc[st.ch];
      rdata_cfg = mem_rdata[18:0];
      reqv = {1'b0, periph_req};
      ackv = {1'b0, st.req_ack};
      for (int k = 0; k < `MDMA_NROUTE; k++)
         outs[k] = (st.route[k] < 5'(`MDMA_NCH)) ? st.trig_out[st.route[k]] : 1'b0;

      if (reg_req.wr)
      begin
         if (reg_req.addr == `MDMA_CTRL)
            next_st.enable = reg_req.wdata[0];
         else if (reg_req.addr == `MDMA_INTSTAT)
            next_st.intstat = st.intstat & ~reg_req.wdata[`MDMA_NCH-1:0];
         else if (reg_req.addr == `MDMA_TABLE)
            next_st.table_base = {reg_req.wdata[31:4], 4'h0};
         else if (reg_req.addr == `MDMA_ROUTE)
         begin
            for (int k = 0; k < `MDMA_NROUTE; k++)
               next_st.route[k] = reg_req.wdata[5*k +: 5];
         end
         else if (ch_space(reg_req.addr) && reg_req.addr[3:0] == `MDMA_CH_CFG)
            next_st.cfg[wch] = mdma_cfg_t'(reg_req.wdata[$bits(mdma_cfg_t)-1:0]);
         else if (ch_space(reg_req.addr) && reg_req.addr[3:0] == `MDMA_CH_XFER)
         begin
            next_st.xfer[wch] = mdma_xfer_t'(reg_req.wdata[$bits(mdma_xfer_t)-1:0]);
            next_st.rem[wch] = next_st.xfer[wch].transfer_count;
            next_st.armed[wch] = 1'b0;
            next_st.desc[wch] = st.table_base + (32'(wch) << `MDMA_D_SHIFT);
            hit = cache_find(st.cache, wch);
            if (hit[2])
               next_st.cache[hit[1:0]].valid = 1'b0;
            hit = cache_find(st.cache, st.ch);
         end
      end

      if (reg_req.rd)
      begin
         if (reg_req.addr == `MDMA_CTRL)
            next_st.rdata = {31'h0000_0000, st.enable};
         else if (reg_req.addr == `MDMA_INTSTAT)
            next_st.rdata = {10'h000, st.intstat};
         else if (reg_req.addr == `MDMA_TABLE)
            next_st.rdata = st.table_base;
         else if (reg_req.addr == `MDMA_ROUTE)
            next_st.rdata = {12'h000, st.route};
         else if (reg_req.addr == `MDMA_ACTIVE)
         begin
            for (int c = 0; c < `MDMA_NCH; c++)
               next_st.rdata[c] = st.xfer[c].valid;
         end
         else if (ch_space(reg_req.addr) && reg_req.addr[3:0] == `MDMA_CH_CFG)
            next_st.rdata = 32'(st.cfg[wch]);
         else if (ch_space(reg_req.addr) && reg_req.addr[3:0] == `MDMA_CH_XFER)
            next_st.rdata = 32'({st.rem[wch], st.xfer[wch][8:0]});
      end

      for (int c = 0; c < `MDMA_NCH; c++)
      begin
         tv[c] = trig_pick(st.cfg[c].trig_sel, trig_ext, outs);
         next_st.trig_prev[c] = tv[c];
         if (st.enable && st.xfer[c].valid && (st.cfg[c].req_en || st.cfg[c].trig_en)
             && (!st.cfg[c].trig_en || st.armed[c])
             && (!st.cfg[c].req_en || (reqv[c] && !ackv[c])))
         begin
            if (!found || st.cfg[c].prio < bprio)
            begin
               found = 1'b1;
               best = 5'(c);
               bprio = st.cfg[c].prio;
            end
         end
      end

      // single master port, never gated by processor sleep
      case (st.fsm)
         st_idle:
         begin
            if (found)
            begin
               next_st.ch = best;
               hit = cache_find(st.cache, best);
               next_st.mem.req = 1'b1;
               next_st.mem.we = 1'b0;
               next_st.mem.size = st.xfer[best].width;
               if (hit[2])
               begin
                  next_st.slot = hit[1:0];
                  next_st.mem.addr = work_addr(st.cache[hit[1:0]].src, st.rem[best],
                                               st.xfer[best].source_step, st.xfer[best].width);
                  next_st.fsm = st_rd;
               end
               else
               begin
                  // end addresses fetched on a miss
                  next_st.slot = st.victim;
                  next_st.victim = st.victim + 2'h1;
                  next_st.cache[st.victim].valid = 1'b0;
                  next_st.ptr = st.desc[best];
                  next_st.mem.addr = st.desc[best] + `MDMA_D_SRC;
                  next_st.fsm = st_srce;
               end
            end
         end
         st_link:
         begin
            if (mem_ack)
            begin
               next_st.ptr = mem_rdata;
               next_st.desc[st.ch] = mem_rdata;
               next_st.mem.addr = mem_rdata + `MDMA_D_CFG;
               next_st.fsm = st_cfg;
            end
         end
         st_cfg:
         begin
            if (mem_ack)
            begin
               // word 0 replaces the transfer configuration
               next_st.xfer[st.ch] = mdma_xfer_t'(rdata_cfg);
               next_st.rem[st.ch] = next_st.xfer[st.ch].transfer_count;
               next_st.mem.addr = st.ptr + `MDMA_D_SRC;
               next_st.fsm = st_srce;
            end
         end
         st_srce:
         begin
            if (mem_ack)
            begin
               next_st.cache[st.slot].src = mem_rdata;
               next_st.mem.addr = st.ptr + `MDMA_D_DST;
               next_st.fsm = st_dste;
            end
         end
         st_dste:
         begin
            if (mem_ack)
            begin
               next_st.cache[st.slot].dst = mem_rdata;
               next_st.cache[st.slot].ch = st.ch;
               next_st.cache[st.slot].valid = 1'b1;
               next_st.mem.req = 1'b0;
               next_st.fsm = st_idle;
            end
         end
         st_rd:
         begin
            if (mem_ack)
            begin
               next_st.data = mem_rdata;
               next_st.mem.we = 1'b1;
               next_st.mem.wdata = mem_rdata;
               next_st.mem.addr = work_addr(cur_c.dst, st.rem[st.ch], cur_x.destination_step,
                                            cur_x.width);
               next_st.fsm = st_wr;
            end
         end
         st_wr:
         begin
            if (mem_ack)
            begin
               next_st.mem.req = 1'b0;
               next_st.mem.we = 1'b0;
               next_st.fsm = st_idle;
               // request acknowledge only on wired channels
               if (st.ch < 5'(`MDMA_NREQ) && cur_g.req_en)
                  next_st.req_ack[st.ch] = 1'b1;
               if (!cur_g.burst)
                  next_st.armed[st.ch] = 1'b0;
               if (st.rem[st.ch] != 10'h000)
                  next_st.rem[st.ch] = st.rem[st.ch] - 10'h001;
               else
               begin
                  next_st.armed[st.ch] = 1'b0;
                  next_st.trig_out[st.ch] = 1'b1;
                  if (cur_x.int_en)
                     next_st.intstat[st.ch] = 1'b1;
                  if (cur_x.reload)
                  begin
                     next_st.mem.req = 1'b1;
                     next_st.mem.size = 2'h2;
                     next_st.mem.addr = st.desc[st.ch] + `MDMA_D_LINK;
                     next_st.cache[st.slot].valid = 1'b0;
                     next_st.fsm = st_link;
                  end
                  else
                  begin
                     next_st.xfer[st.ch].valid = 1'b0;
                  end
               end
            end
         end
         default:
            next_st.fsm = st_idle;
      endcase

      // trigger edges arm last so a new event beats the clear
      for (int c = 0; c < `MDMA_NCH; c++)
      begin
         if (tv[c] && !st.trig_prev[c] && st.cfg[c].trig_en && next_st.xfer[c].valid)
            next_st.armed[c] = 1'b1;
      end
      next_st.irq = |next_st.intstat;
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         st <= '0;
         st.fsm <= st_idle;
         for (int c = 0; c < `MDMA_NCH; c++)
            st.cfg[c].prio <= `MDMA_RST_PRIO;
      end
      else
         st <= next_st;
   end

   assign reg_rdata = st.rdata;
   assign mem = st.mem;
   assign req_ack = st.req_ack;
   assign trig_out = st.trig_out;
   assign irq = st.irq;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_exhaust;
      st.fsm == st_wr && mem_ack && st.rem[st.ch] == 10'h000;
   endsequence

   property p_stop;
      s_exhaust ##0 !cur_x.reload |=> !cur_x.valid && st.fsm == st_idle;
   endproperty
   a_stop: assert property (p_stop) else $error("channel kept running");

   property p_reload;
      s_exhaust ##0 cur_x.reload |=> st.fsm == st_link && st.mem.addr == $past(desc_cur) + `MDMA_D_LINK;
   endproperty
   a_reload: assert property (p_reload) else $error("link not fetched");

   property p_cfg;
      st.fsm == st_cfg && mem_ack |=> st.fsm == st_srce && cur_x == $past(rdata_cfg);
   endproperty
   a_cfg: assert property (p_cfg) else $error("config not replaced");

   property p_int;
      s_exhaust ##0 cur_x.int_en |=> st.intstat[st.ch] ##1 st.irq;
   endproperty
   a_int: assert property (p_int) else $error("interrupt missing");

   property p_trig;
      s_exhaust |=> st.trig_out[st.ch] ##1 !st.trig_out[st.ch];
   endproperty
   a_trig: assert property (p_trig) else $error("trigger out not a pulse");

   property p_move;
      st.fsm == st_rd && mem_ack |=> st.fsm == st_wr && st.mem.we && st.mem.wdata == $past(mem_rdata);
   endproperty
   a_move: assert property (p_move) else $error("read data not written");

   property p_last;
      st.fsm == st_rd && st.rem[st.ch] == 10'h000 && cur_c.valid |-> st.mem.addr == cur_c.src;
   endproperty
   a_last: assert property (p_last) else $error("last element not at end");

   property p_irq;
      st.irq == (|st.intstat);
   endproperty
   a_irq: assert property (p_irq) else $error("irq not merged");

   property p_ack;
      st.fsm == st_wr && mem_ack && st.ch < 5'(`MDMA_NREQ) && cur_g.req_en |=> st.req_ack[st.ch];
   endproperty
   a_ack: assert property (p_ack) else $error("request not acknowledged");

endmodule // mdma_top
`default_nettype wire

// ---- verilog/mdma_regs.svh ----
/*
 constants of the multichannel descriptor dma: counts, register offsets,
 reset values and descriptor word offsets.
 assumes a 10-bit byte address on the register port and 32-bit memory words.
*/
`ifndef MDMA_REGS_SVH
`define MDMA_REGS_SVH
`define MDMA_NCH      22
`define MDMA_NREQ     21
`define MDMA_NTRIG    20
`define MDMA_NEXT     16
`define MDMA_NROUTE   4
`define MDMA_NCACHE   4
`define MDMA_CTRL     10'h000
`define MDMA_INTSTAT  10'h004
`define MDMA_TABLE    10'h008
`define MDMA_ROUTE    10'h00C
`define MDMA_ACTIVE   10'h010
`define MDMA_CH_BASE  10'h100
`define MDMA_CH_LAST  10'h25C
`define MDMA_CH_CFG   4'h0
`define MDMA_CH_XFER  4'h4
`define MDMA_D_CFG    32'h0000_0000
`define MDMA_D_SRC    32'h0000_0004
`define MDMA_D_DST    32'h0000_0008
`define MDMA_D_LINK   32'h0000_000C
`define MDMA_D_SHIFT  4
`define MDMA_RST_PRIO 3'h7
`endif

// ---- verilog/mdma_pkg.sv ----
/*
 types of the multichannel descriptor dma.
 assumes mdma_regs.svh is on the include path.
*/
`default_nettype none
`include "mdma_regs.svh"
package mdma_pkg;
   typedef enum logic [6:0]
   {
      st_idle = 7'h01, st_link = 7'h02, st_cfg = 7'h04, st_srce = 7'h08,
      st_dste = 7'h10, st_rd = 7'h20, st_wr = 7'h40
   } mdma_fsm_t;
   typedef struct packed {
      logic [4:0] trig_sel;
      logic [2:0] prio;
      logic       burst;
      logic       trig_en;
      logic       req_en;
   } mdma_cfg_t;
   typedef struct packed {
      logic [9:0] transfer_count;
      logic [1:0] destination_step;
      logic [1:0] source_step;
      logic [1:0] width;
      logic       int_en;
      logic       reload;
      logic       valid;
   } mdma_xfer_t;
   typedef struct packed {
      logic        valid;
      logic [4:0]  ch;
      logic [31:0] src;
      logic [31:0] dst;
   } mdma_cache_t;
   typedef struct packed {
      logic        req;
      logic        we;
      logic [1:0]  size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mdma_mem_t;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [9:0]  addr;
      logic [31:0] wdata;
   } mdma_reg_t;
   typedef struct packed {
      mdma_fsm_t                          fsm;
      logic                               enable;
      logic [`MDMA_NCH-1:0]               intstat;
      logic [31:0]                        table_base;
      logic [`MDMA_NROUTE-1:0][4:0]       route;
      mdma_cfg_t [`MDMA_NCH-1:0]          cfg;
      mdma_xfer_t [`MDMA_NCH-1:0]         xfer;
      logic [`MDMA_NCH-1:0][9:0]          rem;
      logic [`MDMA_NCH-1:0][31:0]         desc;
      logic [`MDMA_NCH-1:0]               armed;
      logic [`MDMA_NCH-1:0]               trig_prev;
      mdma_cache_t [`MDMA_NCACHE-1:0]     cache;
      logic [1:0]                         victim;
      logic [4:0]                         ch;
      logic [1:0]                         slot;
      logic [31:0]                        data;
      logic [31:0]                        ptr;
      mdma_mem_t                          mem;
      logic [31:0]                        rdata;
      logic                               irq;
      logic [`MDMA_NCH-1:0]               trig_out;
      logic [`MDMA_NREQ-1:0]              req_ack;
   } mdma_core_t;
endpackage
`default_nettype wire

// ---- test/mdma_mem_model.sv ----
/*
 memory partner of the dma master port: word ram answering each request.
 assumes word accesses below byte address 0x1000.
*/
`timescale 1ns/100ps
`default_nettype none
module mdma_mem_model
   import mdma_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire mdma_mem_t   mem,
   input  wire logic        slow,
   output      logic        mem_ack,
   output      logic [31:0] mem_rdata
);
   // ****************
   // memory
   // ****************
   logic [31:0] ram [0:1023];
   logic [1:0]  wait_cnt;
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         mem_ack   <= 1'b0;
         wait_cnt  <= 2'h0;
         mem_rdata <= 32'h5a5a_5a5a;
      end
      else if (mem.req && !mem_ack && (!slow || wait_cnt == 2'h3))
      begin
         mem_ack  <= 1'b1;
         wait_cnt <= 2'h0;
         if (mem.we)
            ram[mem.addr[11:2]] <= mem.wdata;
         mem_rdata <= mem.we ? ~mem_rdata : ram[mem.addr[11:2]];
      end
      else
      begin
         // idle bus shows the inverse so stale data cannot pass
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem.req && !mem_ack)
            wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule // mdma_mem_model
`default_nettype wire

// ---- test/tb.sv ----
/*
 self-checking bench of the dma: register tasks, memory partner, scenarios.
 assumes mdma_regs.svh on the include path and a table base of 0x400.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mdma_regs.svh"
module tb
   import mdma_pkg::*;
;
   // ****************
   // bench
   // ****************
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        slow = 1'b0;
   mdma_reg_t   reg_req = '0;
   logic [20:0] periph_req = '0;
   logic [15:0] trig_ext = '0;
   logic        mem_ack;
   logic [31:0] mem_rdata;
   logic [31:0] reg_rdata;
   mdma_mem_t   mem;
   logic [20:0] req_ack;
   logic [21:0] trig_out;
   logic        irq;
   int          err_count = 0;
   int          checks = 0;
   int          cycles = 0;
   int          req_cnt = 0;
   int          ack_cnt = 0;
   always #5 clk_sys = ~clk_sys;
   mdma_top dut (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .periph_req(periph_req), .trig_ext(trig_ext), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .mem(mem), .req_ack(req_ack), .trig_out(trig_out), .irq(irq));
   mdma_mem_model u_mem (.clk_sys(clk_sys), .rst(rst), .mem(mem), .slow(slow),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (mem.req === 1'b1 && mem_ack === 1'b1)
         req_cnt <= req_cnt + 1;
      if (|req_ack === 1'b1)
         ack_cnt <= ack_cnt + 1;
      if (cycles == 20000)
      begin
         err_count++;
         finish_test;
      end
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk_sys) reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys) reg_req <= '0;
   endtask
   task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
      @(posedge clk_sys) reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk_sys) reg_req <= '0;
      #1 cmp(reg_rdata, exp);
   endtask
   task automatic pulse(input int i);
      @(posedge clk_sys) trig_ext[i] <= 1'b1;
      @(posedge clk_sys) trig_ext[i] <= 1'b0;
   endtask
   task automatic wait_trig(input int c);
      for (int i = 0; i < 400; i++)
      begin
         @(posedge clk_sys) #1;
         if (trig_out[c] === 1'b1)
            break;
      end
      cmp({31'h0, trig_out[c]}, 32'h1);
   endtask
   task automatic desc(input int c, input logic [31:0] s, input logic [31:0] d, input logic [31:0] l);
      u_mem.ram[257 + 4 * c] = s;
      u_mem.ram[258 + 4 * c] = d;
      u_mem.ram[259 + 4 * c] = l;
   endtask
   function automatic logic [31:0] xf(input logic [9:0] n, input logic rl, input logic ie);
      return {13'h0, n, 2'h1, 2'h1, 2'h2, ie, rl, 1'b1};
   endfunction
   function automatic logic [31:0] cf(input logic rq, input logic tg, input logic [2:0] p, input logic [4:0] s);
      return {21'h0, s, p, 1'b1, tg, rq};
   endfunction
   function automatic logic [9:0] cha(input int c);
      return 10'(256 + 16 * c);
   endfunction
   task automatic t_reset;
      rdc(`MDMA_CTRL, 32'h0); // engine off
      rdc(`MDMA_CH_BASE, 32'h0000_0038); // priority 7
      rdc(10'h300, 32'h0); // past last channel
      cmp({31'h0, irq}, 32'h0); // irq low
   endtask
   task automatic t_chain;
      int n;
      desc(21, 32'h0000_010C, 32'h0000_020C, 32'h0);
      desc(5, 32'h0000_020C, 32'h0000_028C, 32'h0);
      wr(`MDMA_ROUTE, 32'h0000_0015); // route channel 21
      wr(cha(5), cf(1'b0, 1'b1, 3'h2, 5'h10)); // route 0 trigger code
      wr(cha(5) + 10'h4, xf(10'h3, 1'b0, 1'b0)); // four elements
      wr(cha(21), cf(1'b0, 1'b1, 3'h0, 5'h0c)); // pin code
      wr(cha(21) + 10'h4, xf(10'h3, 1'b0, 1'b1)); // spare channel
      pulse(12); // trigger start
      wait_trig(5); // chained channel
      for (int i = 0; i < 4; i++)
      begin
         cmp(u_mem.ram[128 + i], 32'hc0de_0000 + i); // start address
         cmp(u_mem.ram[160 + i], 32'hc0de_0000 + i); // whole descriptor
      end
      rdc(`MDMA_INTSTAT, 32'h0020_0000); // end interrupt
      cmp({31'h0, irq}, 32'h1); // merged irq
      wr(`MDMA_INTSTAT, 32'h0020_0000); // clear status
      rdc(`MDMA_ACTIVE, 32'h0); // channel stopped
      n = req_cnt;
      pulse(12); // late trigger
      repeat (40) @(posedge clk_sys);
      cmp(req_cnt, n); // trigger ignored
   endtask
   task automatic t_paced;
      int n;
      int a;
      @(posedge clk_sys) slow <= 1'b1;
      desc(0, 32'h0000_0108, 32'h0000_0308, 32'h0);
      wr(cha(0), cf(1'b1, 1'b1, 3'h1, 5'h0d)); // request and trigger
      wr(cha(0) + 10'h4, xf(10'h2, 1'b0, 1'b0)); // three elements
      n = req_cnt;
      a = ack_cnt;
      pulse(13); // trigger first
      repeat (30) @(posedge clk_sys);
      cmp(req_cnt, n); // waits for request
      @(posedge clk_sys) periph_req[0] <= 1'b1;
      wait_trig(0); // count field
      @(posedge clk_sys) periph_req[0] <= 1'b0;
      #1 cmp(ack_cnt - a, 3); // paced elements
      for (int i = 0; i < 3; i++)
         cmp(u_mem.ram[192 + i], 32'hc0de_0000 + i); // end is last
      slow <= 1'b0;
   endtask
   task automatic t_reload;
      desc(1, 32'h0000_0100, 32'h0000_0340, 32'h0000_0500); // aligned link
      u_mem.ram[320] = xf(10'h0, 1'b0, 1'b1); // new config
      u_mem.ram[321] = 32'h0000_0104;
      u_mem.ram[322] = 32'h0000_0344;
      wr(cha(1), cf(1'b1, 1'b0, 3'h1, 5'h00)); // request start
      wr(cha(1) + 10'h4, xf(10'h0, 1'b1, 1'b0)); // reload on
      @(posedge clk_sys) periph_req[1] <= 1'b1;
      wait_trig(1); // first end
      wait_trig(1); // linked end
      @(posedge clk_sys) periph_req[1] <= 1'b0;
      cmp(u_mem.ram[208], 32'hc0de_0000); // first descriptor
      cmp(u_mem.ram[209], 32'hc0de_0001); // reloaded run
      rdc(`MDMA_INTSTAT, 32'h0000_0002); // int from new config
      wr(`MDMA_INTSTAT, 32'h0000_0002); // clear status
   endtask
   task automatic t_single;
      int n;
      desc(4, 32'h0000_0104, 32'h0000_03a8, 32'h0);
      wr(cha(4), cf(1'b0, 1'b1, 3'h0, 5'h0e) & 32'hffff_fffb); // burst off
      wr(cha(4) + 10'h4, xf(10'h1, 1'b0, 1'b0) ^ 32'h0000_0180); // double destination step
      pulse(14); // one element
      repeat (30) @(posedge clk_sys);
      n = req_cnt;
      cmp(u_mem.ram[232], 32'hc0de_0000); // destination start
      repeat (30) @(posedge clk_sys);
      cmp(req_cnt, n); // waits for next trigger
      pulse(14); // second element
      wait_trig(4); // descriptor ends
      cmp(u_mem.ram[234], 32'hc0de_0001); // stride of two words
   endtask
   task automatic t_prio(input logic [2:0] p2, input logic [2:0] p3, input logic [31:0] exp);
      desc(2, 32'h0000_0100, 32'h0000_0380, 32'h0);
      desc(3, 32'h0000_0104, 32'h0000_0390, 32'h0);
      wr(cha(2), cf(1'b1, 1'b0, p2, 5'h00)); // level of channel 2
      wr(cha(3), cf(1'b1, 1'b0, p3, 5'h00)); // level of channel 3
      wr(cha(2) + 10'h4, xf(10'h0, 1'b0, 1'b0)); // one element
      wr(cha(3) + 10'h4, xf(10'h0, 1'b0, 1'b0)); // one element
      @(posedge clk_sys) periph_req[3:2] <= 2'h3;
      for (int i = 0; i < 100; i++)
      begin
         @(posedge clk_sys) #1;
         if ((mem.req && mem.we && mem_ack) === 1'b1)
            break;
      end
      cmp(mem.addr, exp); // first grant
      repeat (30) @(posedge clk_sys);
      @(posedge clk_sys) periph_req[3:2] <= 2'h0;
   endtask
   task automatic finish_test;
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      for (int i = 0; i < 4; i++)
         u_mem.ram[64 + i] = 32'hc0de_0000 + i;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset;
      wr(`MDMA_TABLE, 32'h0000_0400); // table base
      wr(`MDMA_CTRL, 32'h0000_0001); // engine on
      t_chain;
      t_paced;
      t_reload;
      t_single;
      t_prio(3'h1, 3'h0, 32'h0000_0390); // lower level first
      t_prio(3'h4, 3'h4, 32'h0000_0380); // lowest channel first
      finish_test;
   end
endmodule // tb
`default_nettype wire
